// File: tofs_regs.sv
`timescale 1ns/1ns
// Behaviour
// (RL1) delay register 64h, read/write, protectable
// (RL2) delay resets to ca80h, 0 to 5 s
// (RL3) timing words are linear-11 milliseconds
// (RL4) fall register 65h, honoured one/two phases
// (RL5) fall under 0.5 ms: immediate switch-off
// (RL6) four or more phases: always immediate off
// (RL7) fall resets ca80h, range to 100 ms
// (RL8) status byte 78h is word low byte
// (RL9) bit 7: busy, request not served
// (RL10) bit 6: output not powered, any cause; set here from the first clock after reset whenever the sequencer is not in ST_ON, so also during delay and fall
// (RL11) bits 5,4,3: overvoltage, overcurrent, input undervoltage
// (RL12) bit 2 temperature, bit 1 comms fault
// (RL13) bit 0: other fault, cause in high byte
// (RL14) status word 79h, read-only, resets zero
// (RL15) bits 15..12: vout, iout, input, vendor
// (RL16) bit 11: power good negated
// (RL17) bit 9: any detailed status bit set
// (RL18) host reads detail registers the summary names
// (RL19) exponent bits 15:11, mantissa 10:0, signed
module tofs_regs #(
  parameter int cyc_per_ms = tofs_pkg::CYC_PER_MS
) (
  // core clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    resetn,
  // link side, on the link clock
  input  wire logic                    link_clk,
  input  wire logic                    link_req_valid,
  input  wire tofs_pkg::tofs_req_type  link_req,
  output logic                         link_rsp_valid,
  output logic [15:0]                  link_rsp_data,
  // converter control and monitors
  input  wire logic                    output_enable,
  input  wire logic                    power_good,
  input  wire logic [3:0]              phase_count,
  input  wire logic                    write_protect,
  input  wire logic                    clear_faults,
  input  wire tofs_pkg::tofs_fault_type faults,
  // power stage and status summary
  output logic                         ramp_down,
  output logic                         stage_off,
  output logic [15:0]                  status_summary
);

  localparam int TICK_RAW = cyc_per_ms >> tofs_pkg::FRAC_BITS;
  localparam int TICK_CYC = (TICK_RAW < 1) ? 1 : TICK_RAW;
  localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);
  localparam logic [31:0] FALL_MIN  = 32'(tofs_pkg::FALL_MIN_TICKS);

  typedef struct packed {
    tofs_pkg::tofs_seq_type state;
    logic [31:0] cnt;
    logic [15:0] pre;
    logic        en_s1;
    logic        en_s2;
    logic        pg_s1;
    logic        pg_s2;
    logic        req_s1;
    logic        req_s2;
    logic        req_s3;
    logic        bsy_s1;
    logic        bsy_s2;
    logic        bsy_s3;
    logic [15:0] delay_time;
    logic [15:0] fall_time;
    logic [15:0] sticky;
    logic [15:0] word;
    logic [15:0] rsp_data;
    logic        ack_tog;
    logic        ramp;
    logic        stage_off;
  } tofs_core_type;

  typedef struct packed {
    tofs_pkg::tofs_req_type req;
    logic        req_tog;
    logic        busy_tog;
    logic        ack_s1;
    logic        ack_s2;
    logic        ack_s3;
    logic        rsp_valid;
    logic [15:0] rsp_data;
  } tofs_link_type;

  tofs_core_type c;
  tofs_core_type next_c;
  tofs_link_type l;
  tofs_link_type next_l;

  // linear-11 word to time in 1/1024 ms; negative values count as zero
  function automatic logic [31:0] tofs_lin11_ticks(input logic [15:0] w);
    logic signed [4:0]  n;
    logic signed [10:0] y;
    logic [31:0]        mag;
    int                 sh;
    n   = w[tofs_pkg::LIN_EXP_MSB:tofs_pkg::LIN_EXP_LSB]; // RL19
    y   = w[tofs_pkg::LIN_MANT_MSB:0];
    mag = {21'h0, w[tofs_pkg::LIN_MANT_MSB:0]};
    sh  = int'(n) + tofs_pkg::FRAC_BITS; // RL3
    if (y < 0) begin
      tofs_lin11_ticks = 32'h0;
    end else if (sh < 0) begin
      tofs_lin11_ticks = mag >> (-sh);
    end else if (sh > tofs_pkg::MAX_SHIFT) begin
      // beyond the documented range; saturate rather than wrap
      tofs_lin11_ticks = 32'hffff_ffff;
    end else begin
      tofs_lin11_ticks = mag << sh;
    end
  endfunction : tofs_lin11_ticks

  // summary word from sticky faults and live conditions
  function automatic logic [15:0] tofs_compose(input logic [15:0] st,
                                               input logic        off,
                                               input logic        pg_n,
                                               input logic        other);
    logic [15:0] w;
    w                      = st;
    w[tofs_pkg::BIT_OFF]   = off; // RL10
    w[tofs_pkg::BIT_PG_N]  = pg_n; // RL16
    w[tofs_pkg::BIT_OTHER] = other; // RL17
    w[tofs_pkg::BIT_NONE]  = |st[tofs_pkg::BIT_VOUT:tofs_pkg::BIT_VENDOR]; // RL13
    w[10]                  = 1'b0;
    w[8]                   = 1'b0;
    tofs_compose = w;
  endfunction : tofs_compose

  // ---------------- link domain ----------------
  always_comb begin
    next_l           = l;
    next_l.ack_s1    = c.ack_tog;
    next_l.ack_s2    = l.ack_s1;
    next_l.ack_s3    = l.ack_s2;
    next_l.rsp_valid = l.ack_s2 ^ l.ack_s3;
    // core holds its answer until the next request, so it is stable here
    if (l.ack_s2 ^ l.ack_s3) begin
      next_l.rsp_data = c.rsp_data;
    end
    if (link_req_valid) begin
      if (l.req_tog != l.ack_s3) begin
        // a request still in flight: refuse it and report busy
        next_l.busy_tog = ~l.busy_tog; // RL9
      end else begin
        next_l.req     = link_req;
        next_l.req_tog = ~l.req_tog;
      end
    end
  end

  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  // ---------------- core domain ----------------
  logic        new_req;
  logic        busy_evt;
  logic        tick;
  logic        multi;
  logic        cmd_err;
  logic [15:0] set_bits;
  logic [31:0] fall_ticks;

  always_comb begin
    next_c        = c;
    next_c.en_s1  = output_enable;
    next_c.en_s2  = c.en_s1;
    next_c.pg_s1  = power_good;
    next_c.pg_s2  = c.pg_s1;
    next_c.req_s1 = l.req_tog;
    next_c.req_s2 = c.req_s1;
    next_c.req_s3 = c.req_s2;
    next_c.bsy_s1 = l.busy_tog;
    next_c.bsy_s2 = c.bsy_s1;
    next_c.bsy_s3 = c.bsy_s2;
    new_req       = c.req_s2 ^ c.req_s3;
    busy_evt      = c.bsy_s2 ^ c.bsy_s3;
    cmd_err       = 1'b0;

    // command execution
    if (new_req) begin
      next_c.ack_tog  = ~c.ack_tog;
      next_c.rsp_data = 16'h0000;
      unique case (l.req.code)
        tofs_pkg::CMD_DELAY_TIME: begin
          next_c.rsp_data = c.delay_time; // RL1
          if (l.req.write && write_protect) begin
            cmd_err = 1'b1;
          end else if (l.req.write) begin
            next_c.delay_time = l.req.data; // RL1
          end
        end
        tofs_pkg::CMD_FALL_TIME: begin
          next_c.rsp_data = c.fall_time; // RL4
          if (l.req.write && write_protect) begin
            cmd_err = 1'b1;
          end else if (l.req.write) begin
            next_c.fall_time = l.req.data; // RL4
          end
        end
        tofs_pkg::CMD_SUMMARY_LOW: begin
          next_c.rsp_data = {8'h00, c.word[tofs_pkg::BYTE_MSB:0]}; // RL8
          cmd_err         = l.req.write;
        end
        tofs_pkg::CMD_SUMMARY_FULL: begin
          next_c.rsp_data = c.word; // RL14
          cmd_err         = l.req.write;
        end
        default: begin
          cmd_err = 1'b1;
        end
      endcase
    end

    // sticky fault capture; a set in the clearing cycle survives
    set_bits                        = 16'h0000;
    set_bits[tofs_pkg::BIT_BUSY]    = busy_evt; // RL9
    set_bits[tofs_pkg::BIT_VOUT_OV] = faults.vout_ov; // RL11
    set_bits[tofs_pkg::BIT_IOUT_OC] = faults.iout_oc; // RL11
    set_bits[tofs_pkg::BIT_VIN_UV]  = faults.vin_uv; // RL11
    set_bits[tofs_pkg::BIT_TEMP]    = faults.temp; // RL12
    set_bits[tofs_pkg::BIT_CML]     = faults.cml_ext | cmd_err; // RL12
    set_bits[tofs_pkg::BIT_VOUT]    = faults.vout_any; // RL15
    set_bits[tofs_pkg::BIT_IOUT]    = faults.iout_any; // RL15
    set_bits[tofs_pkg::BIT_INPUT]   = faults.input_any; // RL15
    set_bits[tofs_pkg::BIT_VENDOR]  = faults.vendor_fault_summary; // RL15
    next_c.sticky = (c.sticky & ~{16{clear_faults}}) | set_bits;

    // turn-off sequencer
    tick       = (c.pre == TICK_LAST);
    next_c.pre = tick ? 16'h0000 : c.pre + 16'h0001;
    multi      = (phase_count >= tofs_pkg::MULTI_PHASE_MIN);
    fall_ticks = tofs_lin11_ticks(c.fall_time);
    if (tick && (c.cnt != 32'h0)) begin
      next_c.cnt = c.cnt - 32'h1;
    end
    unique case (c.state)
      tofs_pkg::ST_OFF: begin
        if (c.en_s2) begin
          next_c.state = tofs_pkg::ST_ON;
        end
      end
      tofs_pkg::ST_ON: begin
        if (!c.en_s2) begin
          next_c.state = tofs_pkg::ST_DELAY;
          next_c.cnt   = tofs_lin11_ticks(c.delay_time); // RL2
        end
      end
      tofs_pkg::ST_DELAY: begin
        if (c.en_s2) begin
          next_c.state = tofs_pkg::ST_ON;
        end else if (c.cnt == 32'h0) begin
          if (multi || (fall_ticks < FALL_MIN)) begin
            next_c.state = tofs_pkg::ST_OFF; // RL5 RL6
          end else begin
            next_c.state = tofs_pkg::ST_FALL; // RL7
            next_c.cnt   = fall_ticks;
          end
        end
      end
      tofs_pkg::ST_FALL: begin
        if (c.en_s2) begin
          next_c.state = tofs_pkg::ST_ON;
        end else if (c.cnt == 32'h0) begin
          next_c.state = tofs_pkg::ST_OFF;
        end
      end
      default: begin
        next_c.state = tofs_pkg::ST_OFF;
      end
    endcase
    next_c.ramp      = (next_c.state == tofs_pkg::ST_FALL);
    next_c.stage_off = (next_c.state == tofs_pkg::ST_OFF);
    next_c.word      = tofs_compose(next_c.sticky, next_c.state != tofs_pkg::ST_ON,
                                    ~c.pg_s2, faults.detail_any);
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      c            <= '0;
      c.state      <= tofs_pkg::ST_OFF;
      c.delay_time <= tofs_pkg::RST_DELAY_TIME; // RL2
      c.fall_time  <= tofs_pkg::RST_FALL_TIME; // RL7
      c.sticky     <= tofs_pkg::RST_STATUS;
      c.word       <= tofs_pkg::RST_STATUS; // RL14
      c.stage_off  <= 1'b1;
    end else begin
      c <= next_c;
    end
  end

  assign link_rsp_valid = l.rsp_valid;
  assign link_rsp_data  = l.rsp_data;
  assign ramp_down      = c.ramp;
  assign stage_off      = c.stage_off;
  assign status_summary = c.word;

  // ---------------- checks ----------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  AST_DELAY_READ: assert property ( // RL1
    new_req && !l.req.write && l.req.code == tofs_pkg::CMD_DELAY_TIME
      |=> c.rsp_data == $past(c.delay_time) && c.ack_tog != $past(c.ack_tog))
    else $error("delay read answered wrongly");
  AST_PROTECT: assert property ( // RL4
    new_req && l.req.write && write_protect && l.req.code == tofs_pkg::CMD_FALL_TIME
      |=> $stable(c.fall_time) && c.word[tofs_pkg::BIT_CML])
    else $error("protected fall write not refused");
  AST_BYTE_ALIAS: assert property ( // RL8
    new_req && !l.req.write && l.req.code == tofs_pkg::CMD_SUMMARY_LOW
      |=> c.rsp_data == {8'h00, $past(c.word[7:0])})
    else $error("status byte differs from word low byte");
  AST_MULTI_OFF: assert property ( // RL6
    c.state == tofs_pkg::ST_DELAY && c.cnt == 32'h0 && !c.en_s2 && multi
      |=> c.state == tofs_pkg::ST_OFF ##0 stage_off && !ramp_down)
    else $error("multi-phase turn-off not immediate");
  AST_SHORT_FALL: assert property ( // RL5
    c.state == tofs_pkg::ST_DELAY && c.cnt == 32'h0 && !c.en_s2 && fall_ticks < FALL_MIN
      |=> stage_off)
    else $error("short fall time not immediate");
  AST_RAMP: assert property ( // RL7
    c.state == tofs_pkg::ST_DELAY && c.cnt == 32'h0 && !c.en_s2 && !multi
      && fall_ticks >= FALL_MIN |=> ramp_down && !stage_off)
    else $error("controlled fall not started");
  // one cycle late: the word leaves reset at zero while the state is already off
  AST_OFF_BIT: assert property ( // RL10
    1'b1 |=> status_summary[tofs_pkg::BIT_OFF] == (c.state != tofs_pkg::ST_ON))
    else $error("off bit disagrees with sequencer");
  AST_OVP_STICKY: assert property ( // RL11
    faults.vout_ov |=> status_summary[tofs_pkg::BIT_VOUT_OV]
      ##1 (status_summary[tofs_pkg::BIT_VOUT_OV] || $past(clear_faults)))
    else $error("overvoltage flag lost");
  AST_PG_BIT: assert property ( // RL16
    !c.pg_s2 |=> status_summary[tofs_pkg::BIT_PG_N])
    else $error("power good bit not set");
  AST_OTHER_BIT: assert property ( // RL17
    faults.detail_any |=> status_summary[tofs_pkg::BIT_OTHER])
    else $error("other bit not set");
  AST_NONE_BIT: assert property ( // RL13
    faults.vendor_fault_summary |=> status_summary[tofs_pkg::BIT_NONE])
    else $error("bit 0 not set for high byte fault");

  COV_DELAY_READ: cover property (new_req && l.req.code == tofs_pkg::CMD_DELAY_TIME);
  COV_FALL_WRITE: cover property (new_req && l.req.write
                                  && l.req.code == tofs_pkg::CMD_FALL_TIME);
  COV_RAMP: cover property (c.state == tofs_pkg::ST_FALL ##1 c.state == tofs_pkg::ST_OFF);
  COV_BUSY: cover property (busy_evt);

endmodule : tofs_regs

// File: tofs_pkg.sv
package tofs_pkg;

  // command codes
  localparam logic [7:0]  CMD_DELAY_TIME   = 8'h64;
  localparam logic [7:0]  CMD_FALL_TIME    = 8'h65;
  localparam logic [7:0]  CMD_SUMMARY_LOW  = 8'h78;
  localparam logic [7:0]  CMD_SUMMARY_FULL = 8'h79;

  // reset values
  localparam logic [15:0] RST_DELAY_TIME  = 16'hca80;
  localparam logic [15:0] RST_FALL_TIME   = 16'hca80;
  localparam logic [15:0] RST_STATUS      = 16'h0000;

  // status word bit positions
  localparam int BIT_NONE    = 0;
  localparam int BIT_CML     = 1;
  localparam int BIT_TEMP    = 2;
  localparam int BIT_VIN_UV  = 3;
  localparam int BIT_IOUT_OC = 4;
  localparam int BIT_VOUT_OV = 5;
  localparam int BIT_OFF     = 6;
  localparam int BIT_BUSY    = 7;
  localparam int BIT_OTHER   = 9;
  localparam int BIT_PG_N    = 11;
  localparam int BIT_VENDOR  = 12;
  localparam int BIT_INPUT   = 13;
  localparam int BIT_IOUT    = 14;
  localparam int BIT_VOUT    = 15;
  localparam int BYTE_MSB    = 7;

  // linear-11 layout
  localparam int LIN_EXP_MSB  = 15;
  localparam int LIN_EXP_LSB  = 11;
  localparam int LIN_MANT_MSB = 10;

  // timing: internal time unit is 1/1024 ms
  localparam int FRAC_BITS     = 10;
  localparam int MAX_SHIFT     = 21;
  localparam int CLK_PERIOD_NS = 8;
  localparam int NS_PER_MS     = 1000000;
  localparam int CYC_PER_MS    = NS_PER_MS / CLK_PERIOD_NS;
  localparam int FALL_MIN_US   = 500;
  localparam int US_PER_MS     = 1000;
  localparam int FALL_MIN_TICKS = (FALL_MIN_US * (1 << FRAC_BITS)) / US_PER_MS;
  localparam logic [3:0] MULTI_PHASE_MIN = 4'h4;

  typedef enum logic [3:0] {
    ST_OFF   = 4'b0001,
    ST_ON    = 4'b0010,
    ST_DELAY = 4'b0100,
    ST_FALL  = 4'b1000
  } tofs_seq_type;

  typedef struct packed {
    logic        write;
    logic [7:0]  code;
    logic [15:0] data;
  } tofs_req_type;

  typedef struct packed {
    logic vout_ov;
    logic iout_oc;
    logic vin_uv;
    logic temp;
    logic cml_ext;
    logic vout_any;
    logic iout_any;
    logic input_any;
    logic vendor_fault_summary;
    logic detail_any;
  } tofs_fault_type;

endpackage : tofs_pkg

// File: tofs_host.sv
`timescale 1ns/1ns
module tofs_host (
  // link clock and reset
  input  wire logic                   link_clk,
  input  wire logic                   resetn,
  // request and answer
  output tofs_pkg::tofs_req_type      link_req,
  output logic                        link_req_valid,
  input  wire logic                   link_rsp_valid,
  input  wire logic [15:0]            link_rsp_data
);
  initial begin
    link_req_valid = 1'b0;
    link_req = '0;
  end
  // idle lines show the inverse so stale data never passes for live
  task automatic xfer(input logic wr, input logic [7:0] cd, input logic [15:0] dt,
                      input bit dbl, output logic [15:0] rd);
    int c;
    @(posedge link_clk);
    #1;
    link_req_valid = 1'b1;
    link_req = '{write: wr, code: cd, data: dt};
    @(posedge link_clk);
    #1;
    // a second request while the first is outstanding is meant to be dropped
    if (dbl) begin
      @(posedge link_clk);
      #1;
    end
    link_req_valid = 1'b0;
    link_req = ~link_req;
    rd = 'x;
    c = 0;
    while (c < 20 && resetn === 1'b1) begin
      @(posedge link_clk);
      #1;
      c++;
      if (link_rsp_valid === 1'b1) begin
        rd = link_rsp_data;
        c = 99;
      end
    end
  endtask : xfer
endmodule : tofs_host

// File: turnoff_timing_status_regs_bench.sv
`timescale 1ns/1ns
module turnoff_timing_status_regs_bench;
  localparam int cyc_per_ms = 1024;
  logic                     core_clk, link_clk, resetn, output_enable, power_good;
  logic                     write_protect, clear_faults, link_req_valid, link_rsp_valid;
  logic                     ramp_down, stage_off, mdl_on;
  logic [3:0]               phase_count;
  logic [15:0]              link_rsp_data, status_summary, mdl_sticky, mdl_delay, mdl_fall;
  logic [15:0]              rd, w, old;
  logic [7:0]               cd;
  tofs_pkg::tofs_req_type   link_req;
  tofs_pkg::tofs_fault_type faults;
  int                       miscompares, checks, seed, n;
  int                       fpos[9] = '{5, 4, 3, 2, 1, 15, 14, 13, 12};

  tofs_regs #(.cyc_per_ms(cyc_per_ms)) tofs_regs_inst (.core_clk, .resetn, .link_clk,
    .link_req_valid, .link_req, .link_rsp_valid, .link_rsp_data, .output_enable, .power_good,
    .phase_count, .write_protect, .clear_faults, .faults, .ramp_down, .stage_off,
    .status_summary);
  tofs_host tofs_host_inst (.link_clk, .resetn, .link_req, .link_req_valid, .link_rsp_valid,
    .link_rsp_data);

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // 15 ns link period with a phase unrelated to the core clock
  initial begin
    link_clk = 1'b0;
    #3;
    forever begin
      #7 link_clk = 1'b1;
      #8 link_clk = 1'b0;
    end
  end

  function automatic logic [15:0] exp_stat();
    logic [15:0] s;
    s = mdl_sticky;
    s[6] = !mdl_on;
    s[11] = !power_good;
    s[9] = faults.detail_any;
    s[0] = |mdl_sticky[15:12];
    return s;
  endfunction : exp_stat

  function automatic int ticks(logic [15:0] v);
    int e;
    int y;
    e = $signed(v[15:11]) + 10;
    y = $signed(v[10:0]);
    if (y < 0) return 0;
    return (e >= 0) ? (y << e) : (y >> -e);
  endfunction : ticks

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic rw(input logic wr, input logic [7:0] c, input logic [15:0] d,
                    input logic [15:0] e, input string nm);
    tofs_host_inst.xfer(wr, c, d, 1'b0, rd);
    chk(nm, e, rd);
  endtask : rw

  task automatic clr();
    clear_faults = 1'b1;
    cyc(1);
    clear_faults = 1'b0;
    mdl_sticky = '0;
    cyc(1);
  endtask : clr

  task automatic cml_chk(input string nm);
    cyc(4);
    mdl_sticky[1] = 1'b1;
    chk(nm, exp_stat(), status_summary);
    clr();
  endtask : cml_chk

  task automatic seq(input int d, input int f, input bit ramp);
    int c;
    output_enable = 1'b1;
    cyc(6);
    mdl_on = 1'b1;
    chk("on status", exp_stat(), status_summary);
    chk("on stage", 16'h0000, {15'h0, stage_off});
    output_enable = 1'b0;
    c = 0;
    while (!(ramp_down === 1'b1 || stage_off === 1'b1) && c < 3000) begin
      cyc(1);
      c++;
    end
    chk("ramp mode", {15'h0, ramp}, {15'h0, ramp_down});
    chk("delay span", 16'h0001, {15'h0, c >= d && c <= d + 6});
    c = 0;
    while (ramp_down === 1'b1 && c < 3000) begin
      cyc(1);
      c++;
    end
    chk("fall span", 16'h0001, {15'h0, c >= f - 2 && c <= f + 4});
    cyc(2);
    mdl_on = 1'b0;
    chk("off stage", 16'h0001, {15'h0, stage_off});
    chk("off status", exp_stat(), status_summary);
  endtask : seq

  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  initial begin
    #300000;
    miscompares++;
    wrap_up();
  end

  initial begin
    seed = 32'h93db3077;
    {resetn, output_enable, power_good, write_protect, clear_faults, mdl_on} = '0;
    phase_count = 4'h1;
    faults = '0;
    mdl_sticky = '0;
    mdl_delay = 16'hca80;
    mdl_fall = 16'hca80;
    cyc(1);
    chk("reset status", 16'h0000, status_summary);
    repeat (2) @(posedge core_clk);
    repeat (2) @(posedge link_clk);
    #1 resetn = 1'b1;
    cyc(4);
    chk("status after reset", exp_stat(), status_summary);
    rw(0, tofs_pkg::CMD_DELAY_TIME, 0, 16'hca80, "delay reset");
    rw(0, tofs_pkg::CMD_FALL_TIME, 0, 16'hca80, "fall reset");
    w = exp_stat();
    rw(0, tofs_pkg::CMD_SUMMARY_FULL, 0, w, "word read");
    rw(0, tofs_pkg::CMD_SUMMARY_LOW, 0, {8'h00, w[7:0]}, "byte read");
    $display("test reset done");
    for (n = 0; n < 6; n++) begin
      w = $random(seed);
      w[15] = 1'b1;
      w[10] = 1'b0;
      cd = n[0] ? tofs_pkg::CMD_FALL_TIME : tofs_pkg::CMD_DELAY_TIME;
      old = n[0] ? mdl_fall : mdl_delay;
      rw(1, cd, w, old, "write old value");
      if (n[0]) mdl_fall = w;
      else mdl_delay = w;
      rw(0, cd, 0, w, "read back");
    end
    write_protect = 1'b1;
    cyc(1);
    rw(1, tofs_pkg::CMD_FALL_TIME, 16'h1234, mdl_fall, "protected write");
    rw(0, tofs_pkg::CMD_FALL_TIME, 0, mdl_fall, "protected keep");
    write_protect = 1'b0;
    cml_chk("cml protect");
    w = exp_stat();
    rw(1, tofs_pkg::CMD_SUMMARY_FULL, 16'hffff, w, "word write answer");
    cml_chk("cml read only");
    w = exp_stat();
    rw(1, tofs_pkg::CMD_SUMMARY_LOW, 16'h00ff, {8'h00, w[7:0]}, "byte write answer");
    cml_chk("cml byte read only");
    rw(0, 8'h66, 0, 16'h0000, "unknown code");
    cml_chk("cml unknown");
    tofs_host_inst.xfer(0, tofs_pkg::CMD_DELAY_TIME, 0, 1'b1, rd);
    chk("busy answer", mdl_delay, rd);
    cyc(4);
    mdl_sticky[7] = 1'b1;
    chk("busy bit", exp_stat(), status_summary);
    clr();
    $display("test link done");
    for (n = 0; n < 9; n++) begin
      faults = 10'h200 >> n;
      cyc(1);
      faults = '0;
      mdl_sticky[fpos[n]] = 1'b1;
      cyc(1);
      chk("fault bit", exp_stat(), status_summary);
      rw(0, tofs_pkg::CMD_SUMMARY_FULL, 0, exp_stat(), "summary read");
      clr();
    end
    faults.detail_any = 1'b1;
    cyc(2);
    chk("other bit", exp_stat(), status_summary);
    faults.detail_any = 1'b0;
    power_good = 1'b1;
    cyc(5);
    chk("power good", exp_stat(), status_summary);
    $display("test status done");
    rw(1, tofs_pkg::CMD_DELAY_TIME, 16'hb032, mdl_delay, "delay set");
    rw(1, tofs_pkg::CMD_FALL_TIME, 16'hb258, mdl_fall, "fall set");
    seq(ticks(16'hb032), ticks(16'hb258), 1'b1);
    rw(1, tofs_pkg::CMD_FALL_TIME, 16'hb190, 16'hb258, "short fall set");
    seq(ticks(16'hb032), 0, 1'b0);
    rw(1, tofs_pkg::CMD_FALL_TIME, 16'hb258, 16'hb190, "fall again");
    phase_count = 4'h4;
    seq(ticks(16'hb032), 0, 1'b0);
    // enable back high while the delay still runs must return to on
    output_enable = 1'b1;
    cyc(6);
    output_enable = 1'b0;
    cyc(20);
    output_enable = 1'b1;
    cyc(6);
    mdl_on = 1'b1;
    chk("abort status", exp_stat(), status_summary);
    chk("abort stage", 16'h0000, {15'h0, stage_off});
    $display("test sequencer done");
    wrap_up();
  end
endmodule : turnoff_timing_status_regs_bench
